//--- pkg/sfop_regs.svh
// Purpose: Constants for the status flag set/clear block
// Assumes: Included by bare name
// Notes: Offsets are byte addresses on a 32-bit Wishbone bus
`ifndef SFOP_REGS_SVH
`define SFOP_REGS_SVH
// ==========================================================
// Register offsets
`define SFOP_OFF_STATUS 4'h0
`define SFOP_OFF_OP 4'h4
`define SFOP_OFF_COUNT 4'h8
// ==========================================================
// Status bit positions
`define SFOP_BIT_C 0
`define SFOP_BIT_Z 1
`define SFOP_BIT_N 2
`define SFOP_BIT_V 3
`define SFOP_BIT_S 4
`define SFOP_BIT_H 5
`define SFOP_BIT_T 6
`define SFOP_BIT_I 7
// ==========================================================
// Reset values and field layout
`define SFOP_STATUS_RST 8'h00
`define SFOP_COUNT_RST 16'h0000
`define SFOP_OP_W 4
`define SFOP_COUNT_INC 16'h0001
`define SFOP_UNMAPPED 32'h0000_0000
`endif

//--- pkg/sfop_pkg.sv
// Purpose: Types for the status flag set/clear block
// Assumes: sfop_regs.svh holds the numbers
// Notes: Opcode codes are block-local
package sfop_pkg;
    // ==========================================================
    // Flag operation codes
    typedef enum logic [3:0] {
        sfop_nop_op = 4'h0,
        sfop_raise_negative_op = 4'h1,
        sfop_drop_negative_op = 4'h2,
        sfop_raise_zero_op = 4'h3,
        sfop_drop_zero_op = 4'h4,
        sfop_unmask_interrupts_op = 4'h5,
        sfop_mask_interrupts_op = 4'h6,
        sfop_raise_sign_op = 4'h7,
        sfop_drop_sign_op = 4'h8,
        sfop_raise_overflow_op = 4'h9,
        sfop_drop_overflow_op = 4'hA,
        sfop_raise_transfer_bit_op = 4'hB,
        sfop_drop_transfer_bit_op = 4'hC,
        sfop_raise_half_carry_op = 4'hD,
        sfop_drop_half_carry_op = 4'hE
    } sfop_op_type;

    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        sfop_idle_st = 2'b01,
        sfop_ack_st = 2'b10
    } sfop_state_type;
endpackage

//--- hw/sfop_decode.sv
// Purpose: Decode a flag opcode into set and clear bit masks
// Assumes: Opcode is one of sfop_op_type
// Notes: Purely combinational, at most one mask bit active
`include "sfop_regs.svh"
module sfop_decode
    import sfop_pkg::*;
(
    input wire logic [3:0] op_i,
    output logic [7:0] set_o,
    output logic [7:0] clr_o
);
    // ==========================================================
    // Opcode to one-bit masks
    always_comb
    begin
        set_o = 8'h00;
        clr_o = 8'h00;
        case (sfop_op_type'(op_i))
            sfop_raise_negative_op: set_o[`SFOP_BIT_N] = 1'b1;
            sfop_drop_negative_op: clr_o[`SFOP_BIT_N] = 1'b1;
            sfop_raise_zero_op: set_o[`SFOP_BIT_Z] = 1'b1;
            sfop_drop_zero_op: clr_o[`SFOP_BIT_Z] = 1'b1;
            sfop_unmask_interrupts_op: set_o[`SFOP_BIT_I] = 1'b1;
            sfop_mask_interrupts_op: clr_o[`SFOP_BIT_I] = 1'b1;
            sfop_raise_sign_op: set_o[`SFOP_BIT_S] = 1'b1;
            sfop_drop_sign_op: clr_o[`SFOP_BIT_S] = 1'b1;
            sfop_raise_overflow_op: set_o[`SFOP_BIT_V] = 1'b1;
            sfop_drop_overflow_op: clr_o[`SFOP_BIT_V] = 1'b1;
            sfop_raise_transfer_bit_op: set_o[`SFOP_BIT_T] = 1'b1;
            sfop_drop_transfer_bit_op: clr_o[`SFOP_BIT_T] = 1'b1;
            sfop_raise_half_carry_op: set_o[`SFOP_BIT_H] = 1'b1;
            sfop_drop_half_carry_op: clr_o[`SFOP_BIT_H] = 1'b1;
            default:
            begin
                set_o = 8'h00;
                clr_o = 8'h00;
            end
        endcase
    end
endmodule

//--- hw/sfop_core.sv
// Purpose: Status register with single-flag set/clear operations
// Assumes: Classic Wishbone slave, 32-bit data, one clock
// Notes: Ops come from the op port or from a bus write to the op register
`include "sfop_regs.svh"
module sfop_core
    import sfop_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire logic [3:0] op_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [7:0] status_register_o,
    output logic int_enable_o
);
    // ==========================================================
    // State
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    sfop_state_type state_r;
    sfop_state_type state_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic [3:0] op_sel;
    logic op_go;
    logic bus_op;
    logic bus_wr_status;
    logic [7:0] set_m;
    logic [7:0] clr_m;

    // ==========================================================
    // Operation source: bus write wins over the op port
    assign bus_op = (state_r == sfop_idle_st) && wb_cyc_i && wb_stb_i && wb_we_i
        && wb_sel_i[0] && (wb_adr_i == `SFOP_OFF_OP);
    assign bus_wr_status = (state_r == sfop_idle_st) && wb_cyc_i && wb_stb_i
        && wb_we_i && wb_sel_i[0] && (wb_adr_i == `SFOP_OFF_STATUS);
    assign op_sel = bus_op ? wb_dat_i[`SFOP_OP_W-1:0] : op_i;
    assign op_go = bus_op || op_valid_i;

    sfop_decode u_decode
    (
        .op_i(op_sel),
        .set_o(set_m),
        .clr_o(clr_m)
    );

    // ==========================================================
    // Status update: a flag op moves only the named bit, a status write loads all eight, in one cycle
    always_comb
    begin
        status_nxt = status_r;
        count_nxt = count_r;
        if (bus_wr_status)
        begin
            status_nxt = wb_dat_i[7:0];
        end
        else if (op_go)
        begin
            status_nxt = (status_r | set_m) & ~clr_m;
            if ((set_m | clr_m) != 8'h00)
            begin
                count_nxt = count_r + `SFOP_COUNT_INC;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status_r <= `SFOP_STATUS_RST;
            count_r <= `SFOP_COUNT_RST;
        end
        else
        begin
            status_r <= status_nxt;
            count_r <= count_nxt;
        end
    end

    // ==========================================================
    // Wishbone slave: ack one cycle after request, then drop
    always_comb
    begin
        state_nxt = state_r;
        dat_nxt = dat_r;
        case (state_r)
            sfop_idle_st:
            begin
                if (wb_cyc_i && wb_stb_i)
                begin
                    state_nxt = sfop_ack_st;
                    case (wb_adr_i)
                        `SFOP_OFF_STATUS: dat_nxt = {24'h00_0000, status_r};
                        `SFOP_OFF_COUNT: dat_nxt = {16'h0000, count_r};
                        default: dat_nxt = `SFOP_UNMAPPED;
                    endcase
                end
            end
            sfop_ack_st:
            begin
                state_nxt = sfop_idle_st;
            end
            default:
            begin
                state_nxt = sfop_idle_st;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= sfop_idle_st;
            dat_r <= `SFOP_UNMAPPED;
        end
        else
        begin
            state_r <= state_nxt;
            dat_r <= dat_nxt;
        end
    end

    // ==========================================================
    // Outputs straight from flip-flops
    assign wb_ack_o = (state_r == sfop_ack_st);
    assign wb_dat_o = dat_r;
    assign status_register_o = status_r;
    assign int_enable_o = status_r[`SFOP_BIT_I];
endmodule

//--- verification/sfop_core_assertions.sv
// Purpose: Port checks for the flag block
// Assumes: One clock, synchronous reset
// Notes: Bound onto sfop_core
module sfop_core_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire logic [3:0] op_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] status_register_o,
    input wire logic int_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Flag op and bus checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic quiet = !(wb_cyc_i && wb_stb_i);
    // Set code c or clear code c+1 lands on bit b one cycle later
    property flag_op(logic [3:0] c, int b);
        quiet && op_valid_i && (op_i == c || op_i == c + 4'h1)
            |=> status_register_o[b] == ($past(op_i) == c);
    endproperty
    a_neg_ops: assert property (flag_op(4'h1, 2)) else $error("negative flag op");
    a_zero_ops: assert property (flag_op(4'h3, 1)) else $error("zero flag op");
    a_int_ops: assert property (flag_op(4'h5, 7)) else $error("interrupt op");
    a_sign_ops: assert property (flag_op(4'h7, 4)) else $error("sign flag op");
    a_ovf_ops: assert property (flag_op(4'h9, 3)) else $error("overflow op");
    a_tbit_ops: assert property (flag_op(4'hB, 6)) else $error("transfer bit op");
    a_half_ops: assert property (flag_op(4'hD, 5)) else $error("half carry op");
    a_one_bit: assert property (quiet && op_valid_i |=>
        $countones(status_register_o ^ $past(status_register_o)) <= 1) else $error("many bits");
    a_idle_hold: assert property (quiet && !op_valid_i |=> $stable(status_register_o))
        else $error("status moved");
    a_int_mirror: assert property (int_enable_o == status_register_o[7])
        else $error("enable mismatch");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_follow: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_status_write: assert property (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
        && !wb_ack_o && wb_adr_i == 4'h0 |=> status_register_o == $past(wb_dat_i[7:0]))
        else $error("status write lost");
    // Main scenarios reached
    cover property (quiet && op_valid_i && op_i == 4'h5);
    cover property (wb_ack_o && wb_we_i);
    cover property (op_valid_i && !quiet);
endmodule

bind sfop_core sfop_core_assertions u_chk (.clk_i, .rst_i, .op_valid_i, .op_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .status_register_o, .int_enable_o);

//--- verification/test_status_flag_set_clear_ops.sv
// Purpose: Self-checking bench for the flag block
// Assumes: Ack one cycle after request, ops apply in one cycle
// Notes: Port ops, bus ops and bus-over-port priority
`include "sfop_regs.svh"
module test_status_flag_set_clear_ops;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, op_valid_i = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic [3:0] op_i = 4'h0, wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic wb_ack_o, int_enable_o;
    logic [7:0] status_register_o;
    int mismatches = 0, n_tests = 0;
    int flag_bit [7] = '{`SFOP_BIT_N, `SFOP_BIT_Z, `SFOP_BIT_I, `SFOP_BIT_S, `SFOP_BIT_V,
        `SFOP_BIT_T, `SFOP_BIT_H};
    sfop_core u_dut (.clk_i, .rst_i, .op_valid_i, .op_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .status_register_o, .int_enable_o);
    // ==========================================================
    // Clock and common tasks
    initial forever #4 clk_i = ~clk_i;
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One classic bus cycle, entered just after an edge
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        {wb_adr_i, wb_we_i, wb_dat_i, wb_sel_i, wb_cyc_i, wb_stb_i} <= {a, w, d, s, 2'b11};
        do
        begin
            @(posedge clk_i);
            op_valid_i <= 1'b0;
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (wb_ack_o !== 1'b1)
        begin
            mismatches++;
            $display("[FAIL] %0t ns: bus cycle timed out", $time);
            tally_and_finish();
        end
        @(posedge clk_i);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_ops(input logic [7:0] start);
        logic [7:0] exp;
        @(posedge clk_i);
        wb(`SFOP_OFF_STATUS, 1'b1, {24'h00_0000, start}, 4'h1);
        exp = start;
        for (int k = 1; k <= 15; k++)
        begin
            @(posedge clk_i);
            op_valid_i <= (k < 15);
            op_i <= k[3:0];
            #1;
            if (k > 1) chk(status_register_o, exp);
            if (k > 1) chk(int_enable_o, exp[7]);
            if (k < 15) exp[flag_bit[(k - 1) / 2]] = k[0];
        end
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        op_i <= 4'h0;
        @(posedge clk_i);
        op_i <= 4'hF;
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        #1;
        chk(status_register_o, exp);
        $display("t_ops done");
    endtask
    task automatic t_bus;
        chk(status_register_o, 8'h00);
        wb(`SFOP_OFF_COUNT, 1'b0, 32'h0000_0000, 4'h1);
        chk(rd, 32'h0000_0000);
        wb(`SFOP_OFF_OP, 1'b1, 32'h0000_0005, 4'h1);
        chk(int_enable_o, 1'b1);
        wb(`SFOP_OFF_OP, 1'b1, 32'h0000_0003, 4'h0);
        wb(`SFOP_OFF_COUNT, 1'b0, 32'h0000_0000, 4'h1);
        chk(rd, 32'h0000_0001);
        wb(4'hC, 1'b1, 32'h0000_00FF, 4'h1);
        wb(4'hC, 1'b0, 32'h0000_0000, 4'h1);
        chk(rd, 32'h0000_0000);
        wb(`SFOP_OFF_OP, 1'b0, 32'h0000_0000, 4'h1);
        chk(rd, 32'h0000_0000);
        wb(`SFOP_OFF_STATUS, 1'b0, 32'h0000_0000, 4'h1);
        chk(rd, 32'h0000_0080);
        op_valid_i <= 1'b1;
        op_i <= 4'h1;
        wb(`SFOP_OFF_STATUS, 1'b1, 32'h0000_0010, 4'h1);
        chk(status_register_o, 8'h10);
        $display("t_bus done");
    endtask
    // Reset, then the scenarios in turn
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_bus();
        t_ops(8'h00);
        t_ops(8'hFF);
        tally_and_finish();
    end
endmodule
